// ---- rtl/edr_ctrl.sv ----
/*
  Host-side controller for an asynchronous 16-bit extended_data_out memory.
  Assumes synchronous user requests and data_lines sampled on CLK_SYS.
*/
module edr_ctrl #(
  parameter int INIT_CYC = edr_pkg::INIT_CYC
) (
  // Clock and reset
  input  wire logic                          CLK_SYS,
  input  wire logic                          RST_B,
  // User request
  input  wire logic                          REQ_VALID,
  input  wire edr_pkg::edr_req_t             REQ,
  output logic                               REQ_READY,
  output logic                               RD_VALID,
  output logic [edr_pkg::DATA_W-1:0]         RD_DATA,
  // Power management
  input  wire logic                          SELF_REFRESH_REQ,
  output logic                               SELF_REFRESH_ACT,
  output logic                               INIT_DONE,
  // Memory pins
  output logic                               ROW_STROBE_N,
  output logic                               LOWER_COLUMN_STROBE_N,
  output logic                               UPPER_COLUMN_STROBE_N,
  output logic                               WRITE_STROBE_N,
  output logic                               OUTPUT_GATE_N,
  output logic [edr_pkg::ADDR_W-1:0]         MEM_ADDR,
  input  wire logic [edr_pkg::DATA_W-1:0]    DATA_LINES_I,
  output logic [edr_pkg::DATA_W-1:0]         DATA_LINES_O,
  output logic                               DATA_LINES_OE
);

  localparam int CW   = 16;
  localparam int RP   = edr_pkg::RP_CYC;
  localparam int RASS = edr_pkg::RASS_CYC;
  localparam int WAKE = edr_pkg::WAKE_CYCLES;
  localparam int REFI = edr_pkg::REFI_CYC;

  if (INIT_CYC < 1 || INIT_CYC >= 2 ** CW || edr_pkg::COL_CYC < 1) begin : g_chk
    $error("edr_ctrl: bad timing parameters");
  end

  edr_pkg::edr_state_t  st_q, st_d;
  edr_pkg::edr_strobe_t strb_q;
  edr_pkg::edr_req_t    req_q, src;
  logic [CW-1:0]        cnt_q;
  logic [3:0]           wake_q;
  logic                 self_q, init_q, ready_q, need, due, overdue;
  logic                 take, reload, ref_ack, ref_clr;
  logic [edr_pkg::ADDR_W-1:0] addr_q;
  logic [edr_pkg::DATA_W-1:0] dout_q, rd_q;
  logic                 oe_q, rdv_q, sact_q;

  function automatic logic last(input logic [CW-1:0] c, input int n);
    return c == CW'(n - 1);
  endfunction

  // Early write only: gate high on writes, low on reads
  function automatic edr_pkg::edr_strobe_t strobe_of(input edr_pkg::edr_state_t s,
                                                     input edr_pkg::edr_req_t r);
    edr_pkg::edr_strobe_t v;
    v = edr_pkg::STRB_IDLE;
    case (s)
      edr_pkg::S_ROW: begin
        v.ras_n = 1'b0;
      end
      edr_pkg::S_COL: begin
        v.ras_n  = 1'b0;
        v.lower_column_strobe_n = !r.be[0];
        v.upper_column_strobe_n = !r.be[1];
        v.we_n   = !r.write;
        v.oe_n   = r.write;
      end
      edr_pkg::S_RCAS: begin
        v.lower_column_strobe_n = 1'b0;
        v.upper_column_strobe_n = 1'b0;
      end
      edr_pkg::S_RRAS, edr_pkg::S_SELF: begin
        v.ras_n  = 1'b0;
        v.lower_column_strobe_n = 1'b0;
        v.upper_column_strobe_n = 1'b0;
      end
      default: begin
      end
    endcase
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  assign need = (wake_q != 4'h0) || due || overdue || (SELF_REFRESH_REQ && init_q);
  assign take = (st_q == edr_pkg::S_IDLE) && ready_q && REQ_VALID;
  assign src  = take ? REQ : req_q;

  always_comb begin
    st_d = st_q;
    case (st_q)
      edr_pkg::S_PWR:   if (last(cnt_q, INIT_CYC)) st_d = edr_pkg::S_RCAS;
      edr_pkg::S_IDLE: begin
        if (take) begin
          st_d = edr_pkg::S_ROW;
        end else if (need) begin
          st_d = edr_pkg::S_RCAS;
        end
      end
      edr_pkg::S_ROW:   if (last(cnt_q, edr_pkg::RCD_CYC)) st_d = edr_pkg::S_COL;
      edr_pkg::S_COL:   if (last(cnt_q, edr_pkg::COL_CYC)) st_d = edr_pkg::S_PRE;
      edr_pkg::S_PRE:   if (last(cnt_q, RP)) st_d = edr_pkg::S_IDLE;
      edr_pkg::S_RCAS:  if (last(cnt_q, edr_pkg::CSR_CYC)) st_d = edr_pkg::S_RRAS;
      edr_pkg::S_RRAS: begin
        if (last(cnt_q, edr_pkg::RAS_CYC)) begin
          st_d = self_q ? edr_pkg::S_SELF : edr_pkg::S_RPRE;
        end
      end
      edr_pkg::S_RPRE:  if (last(cnt_q, RP)) st_d = edr_pkg::S_IDLE;
      edr_pkg::S_SELF: begin
        if (!SELF_REFRESH_REQ && cnt_q >= CW'(RASS - 1)) st_d = edr_pkg::S_SEXIT;
      end
      edr_pkg::S_SEXIT: if (last(cnt_q, edr_pkg::RPS_CYC)) st_d = edr_pkg::S_IDLE;
      default:          st_d = edr_pkg::S_IDLE;
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      st_q  <= edr_pkg::S_PWR;
      cnt_q <= '0;
    end else begin
      st_q  <= st_d;
      cnt_q <= (st_d != st_q) ? '0 : ((&cnt_q) ? cnt_q : cnt_q + CW'(1));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wake-up, self refresh and readiness
  assign reload  = (st_q == edr_pkg::S_IDLE) && (st_d == edr_pkg::S_RCAS) && overdue;
  assign ref_ack = (st_q == edr_pkg::S_RPRE) && (st_d == edr_pkg::S_IDLE);
  assign ref_clr = reload || ((st_q == edr_pkg::S_SEXIT) && (st_d == edr_pkg::S_IDLE));

  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      wake_q <= 4'h0;
      init_q <= 1'b0;
    end else if ((st_q == edr_pkg::S_PWR && st_d != edr_pkg::S_PWR) || reload) begin
      wake_q <= 4'(WAKE);
      init_q <= 1'b0;
    end else if (ref_ack && wake_q != 4'h0) begin
      wake_q <= wake_q - 4'h1;
      init_q <= (wake_q == 4'h1);
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      self_q <= 1'b0;
    end else if (st_q == edr_pkg::S_IDLE && st_d == edr_pkg::S_RCAS) begin
      self_q <= SELF_REFRESH_REQ && init_q && !overdue && (wake_q == 4'h0);
    end else if (st_q == edr_pkg::S_SEXIT) begin
      self_q <= 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      ready_q <= 1'b0;
    end else begin
      ready_q <= (st_q == edr_pkg::S_IDLE) && (st_d == edr_pkg::S_IDLE) && init_q && !need;
    end
  end

  edr_refresh_timer #(
    .REFI_CYC (REFI),
    .ROWS     (edr_pkg::REF_ROWS)
  ) u_timer (
    .clk_sys  (CLK_SYS),
    .rst_b    (RST_B),
    .run      (init_q && !self_q),
    .ack      (ref_ack),
    .clr      (ref_clr),
    .due      (due),
    .overdue  (overdue)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Pins, registered from the next state
  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      strb_q <= edr_pkg::STRB_IDLE;
      sact_q <= 1'b0;
    end else begin
      strb_q <= strobe_of(st_d, src);
      sact_q <= (st_d == edr_pkg::S_SELF);
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      req_q  <= '0;
      addr_q <= '0;
      dout_q <= '0;
      oe_q   <= 1'b0;
    end else begin
      if (take) req_q <= REQ;
      if (st_d == edr_pkg::S_ROW) addr_q <= src.addr[edr_pkg::ROW_LSB +: edr_pkg::ADDR_W];
      if (st_d == edr_pkg::S_COL) addr_q <= src.addr[edr_pkg::ADDR_W-1:0];
      dout_q <= src.wdata;
      oe_q   <= (st_d == edr_pkg::S_COL) && src.write;
    end
  end

  // Sampled on the edge that raises the column strobes
  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      rd_q  <= '0;
      rdv_q <= 1'b0;
    end else begin
      rdv_q <= (st_q == edr_pkg::S_COL) && (st_d != edr_pkg::S_COL) && !req_q.write;
      if ((st_q == edr_pkg::S_COL) && (st_d != edr_pkg::S_COL) && !req_q.write) begin
        rd_q <= DATA_LINES_I;
      end
    end
  end

  assign ROW_STROBE_N          = strb_q.ras_n;
  assign LOWER_COLUMN_STROBE_N = strb_q.lower_column_strobe_n;
  assign UPPER_COLUMN_STROBE_N = strb_q.upper_column_strobe_n;
  assign WRITE_STROBE_N        = strb_q.we_n;
  assign OUTPUT_GATE_N         = strb_q.oe_n;
  assign MEM_ADDR              = addr_q;
  assign DATA_LINES_O          = dout_q;
  assign DATA_LINES_OE         = oe_q;
  assign REQ_READY             = ready_q;
  assign RD_VALID              = rdv_q;
  assign RD_DATA               = rd_q;
  assign INIT_DONE             = init_q;
  assign SELF_REFRESH_ACT      = sact_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  logic [CW-1:0] since_q, gap_q, sc_q;
  logic [3:0]    wref_q;
  logic          ref_fall;

  assign ref_fall = !strb_q.ras_n && !strb_q.lower_column_strobe_n &&
                    (st_q == edr_pkg::S_RRAS) && cnt_q == '0;

  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      since_q <= '0;
      gap_q   <= '0;
      sc_q    <= '0;
      wref_q  <= 4'h0;
    end else begin
      since_q <= (&since_q) ? since_q : since_q + CW'(1);
      gap_q   <= (ref_fall || !init_q || sact_q) ? '0 : gap_q + CW'(1);
      sc_q    <= !sact_q ? '0 : ((&sc_q) ? sc_q : sc_q + CW'(1));
      wref_q  <= init_q ? 4'h0 : (ref_fall ? wref_q + 4'h1 : wref_q);
    end
  end

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_B);

  sequence s_ref_fall;
    $fell(ROW_STROBE_N) && !LOWER_COLUMN_STROBE_N;
  endsequence
  sequence s_rps;
    ROW_STROBE_N [*3];
  endsequence

  a_init_wait:   assert property ($fell(ROW_STROBE_N) |-> since_q >= CW'(INIT_CYC))
    else $error("row strobe fell before power-up pause");
  a_wake_count:  assert property ($rose(INIT_DONE) |-> wref_q == 4'(WAKE))
    else $error("ready without eight wake-up refreshes");
  a_precharge:   assert property ($rose(ROW_STROBE_N) |=>
                   ROW_STROBE_N && LOWER_COLUMN_STROBE_N && UPPER_COLUMN_STROBE_N)
    else $error("precharge too short");
  a_read_we:     assert property (!OUTPUT_GATE_N |-> WRITE_STROBE_N ##1 WRITE_STROBE_N)
    else $error("write strobe low around a read");
  a_early_write: assert property ($fell(WRITE_STROBE_N) |-> DATA_LINES_OE && OUTPUT_GATE_N
                   && $past(LOWER_COLUMN_STROBE_N && UPPER_COLUMN_STROBE_N))
    else $error("write strobe not an early write");
  a_byte_lanes:  assert property ((st_q == edr_pkg::S_COL) |->
                   {UPPER_COLUMN_STROBE_N, LOWER_COLUMN_STROBE_N} == ~req_q.be)
    else $error("column strobes do not match byte enables");
  a_ref_order:   assert property (s_ref_fall |-> $past(!LOWER_COLUMN_STROBE_N
                   && !UPPER_COLUMN_STROBE_N) ##1 !LOWER_COLUMN_STROBE_N)
    else $error("refresh column strobes out of order");
  a_refresh_gap: assert property (gap_q <= CW'(REFI + 16))
    else $error("refresh interval exceeded");
  a_self_exit:   assert property ($fell(SELF_REFRESH_ACT) |-> s_rps ##0
                   $past(sc_q, 2) >= CW'(RASS))
    else $error("self refresh hold or exit precharge short");

endmodule

// ---- pkg/edr_pkg.sv ----
/*
  Shared constants and types for the extended_data_out memory controller.
  Assumes one 25 MHz system clock and a 1M x 16 memory with ten address pins.
*/
package edr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and memory geometry
  localparam int CLK_NS      = 40;
  localparam int ADDR_W      = 10;
  localparam int DATA_W      = 16;
  localparam int ROW_LSB     = 10;
  localparam int REF_ROWS    = 1024;
  localparam int WAKE_CYCLES = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Strobe timing, slowest speed grade
  localparam int T_RP_NS    = 40;
  localparam int T_RAS_NS   = 60;
  localparam int T_RCD_NS   = 14;
  localparam int T_RAC_NS   = 60;
  localparam int T_CSR_NS   = 5;
  localparam int T_RPS_NS   = 104;
  localparam int T_RASS_US  = 100;
  localparam int T_INIT_US  = 200;
  localparam int T_REF_MS   = 16;

  // Least times round up, never below one cycle
  function automatic int cyc_up(input int ns);
    return (ns <= 0) ? 1 : (ns + CLK_NS - 1) / CLK_NS;
  endfunction

  localparam int RP_CYC   = cyc_up(T_RP_NS);
  localparam int RAS_CYC  = cyc_up(T_RAS_NS);
  localparam int RCD_CYC  = cyc_up(T_RCD_NS);
  localparam int COL_CYC  = cyc_up(T_RAC_NS - RCD_CYC * CLK_NS);
  localparam int CSR_CYC  = cyc_up(T_CSR_NS);
  localparam int RPS_CYC  = cyc_up(T_RPS_NS);
  localparam int RASS_CYC = cyc_up(T_RASS_US * 1000);
  localparam int INIT_CYC = cyc_up(T_INIT_US * 1000);
  // Longest interval rounds down
  localparam int REFI_CYC = (T_REF_MS * 1000000 / REF_ROWS) / CLK_NS;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum {
    S_PWR, S_IDLE, S_ROW, S_COL, S_PRE, S_RCAS, S_RRAS, S_RPRE, S_SELF, S_SEXIT
  } edr_state_t;

  typedef struct packed {
    logic ras_n;
    logic lower_column_strobe_n;
    logic upper_column_strobe_n;
    logic we_n;
    logic oe_n;
  } edr_strobe_t;

  localparam edr_strobe_t STRB_IDLE = 5'h1F;

  typedef struct packed {
    logic              write;
    logic [1:0]        be;
    logic [19:0]       addr;
    logic [DATA_W-1:0] wdata;
  } edr_req_t;

endpackage

// ---- rtl/edr_refresh_timer.sv ----
/*
  Refresh interval timer with a count of owed refresh cycles.
  Assumes the sequencer acks each completed refresh and clears on an overdue wake-up reload and after self-refresh exit.
*/
module edr_refresh_timer #(
  parameter int REFI_CYC = edr_pkg::REFI_CYC,
  parameter int ROWS     = edr_pkg::REF_ROWS
) (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_b,
  // Control
  input  wire logic run,
  input  wire logic ack,
  input  wire logic clr,
  // Status
  output logic      due,
  output logic      overdue
);

  localparam int TW = $clog2(REFI_CYC + 1);
  localparam int OW = $clog2(ROWS + 1);

  if (REFI_CYC < 2 || ROWS < 1) begin : g_chk
    $error("edr_refresh_timer: bad parameters");
  end

  logic [TW-1:0] tick_q;
  logic [OW-1:0] owed_q;
  logic          tick;
  logic          inc;
  logic          dec;

  assign tick = run && (tick_q == TW'(REFI_CYC - 1));
  assign inc  = tick && (owed_q != OW'(ROWS));
  assign dec  = ack && (owed_q != '0);

  always_ff @(posedge clk_sys) begin
    if (!rst_b || !run || tick) begin
      tick_q <= '0;
    end else begin
      tick_q <= tick_q + TW'(1);
    end
  end

  // A tick and an ack together cancel, so no owed cycle is lost
  always_ff @(posedge clk_sys) begin
    if (!rst_b || clr) begin
      owed_q <= '0;
    end else if (inc && !dec) begin
      owed_q <= owed_q + OW'(1);
    end else if (dec && !inc) begin
      owed_q <= owed_q - OW'(1);
    end
  end

  assign due     = (owed_q != '0);
  assign overdue = (owed_q == OW'(ROWS));

endmodule

// ---- dv/edr_mem_model.sv ----
/*
  Behavioural 16-bit extended_data_out memory facing the controller pins.
  Assumes registered strobes from the controller and one shared clock.
*/
module edr_mem_model (
  // Clock
  input  wire logic                       clk,
  // Strobes and address
  input  wire logic                       ras_n,
  input  wire logic                       lower_column_strobe_n,
  input  wire logic                       upper_column_strobe_n,
  input  wire logic                       we_n,
  input  wire logic                       oe_n,
  input  wire logic [edr_pkg::ADDR_W-1:0] addr,
  // Data lines
  input  wire logic [edr_pkg::DATA_W-1:0] din,
  input  wire logic                       din_oe,
  output logic      [edr_pkg::DATA_W-1:0] dout,
  // Status
  output int                              refreshes,
  output int                              faults
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem [int];
  logic [9:0]  row_q;
  logic [15:0] rd_q;
  logic [15:0] last_q;
  logic [1:0]  drv;
  logic [1:0]  lane;
  logic [1:0]  lane_q;
  logic        ras_q;
  logic        we_q;
  int          key;

  initial begin
    refreshes = 0;
    faults = 0;
    last_q = 16'h0000;
    rd_q = 16'h0000;
    row_q = 10'h000;
    lane_q = 2'h3;
    ras_q = 1'b1;
    we_q = 1'b1;
  end

  assign lane = {upper_column_strobe_n, lower_column_strobe_n};

  ////////////////////////////////////////////////////////////////////////////
  // Mid-cycle sampling: strobes, address and data all settled, no edge races
  always @(negedge clk) begin
    // Row fall with a column low means internal counter refresh
    if (ras_q && !ras_n) begin
      if (lane != 2'h3) begin
        refreshes++;
      end else begin
        row_q = addr;
        if (refreshes < 8) faults++;
      end
    end
    // Early write when write strobe is already low at column fall
    if (!ras_n && ((lane_q & ~lane) != 2'h0)) begin
      key = int'({row_q, addr});
      rd_q = mem.exists(key) ? mem[key] : 16'h0000;
      if (!we_n) begin
        if (!lane[0]) rd_q[7:0] = din[7:0];
        if (!lane[1]) rd_q[15:8] = din[15:8];
        mem[key] = rd_q;
      end
    end
    // Late write or read-write cycles are not modelled
    if (!ras_n && we_q && !we_n && (lane_q != 2'h3)) faults++;
    ras_q = ras_n;
    lane_q = lane;
    we_q = we_n;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Each lane drives only with its own column strobe; released lanes toggle
  assign drv[0] = !ras_n && !lane[0] && we_n && !oe_n;
  assign drv[1] = !ras_n && !lane[1] && we_n && !oe_n;
  assign dout[7:0] = drv[0] ? rd_q[7:0] : ~last_q[7:0];
  assign dout[15:8] = drv[1] ? rd_q[15:8] : ~last_q[15:8];

  always @(posedge clk) begin
    last_q <= dout;
    if (din_oe && (drv != 2'h0)) faults++;
  end
endmodule

// ---- dv/edr_ctrl_tb_top.sv ----
/*
  Self-checking bench for the extended_data_out memory controller.
  Assumes the memory model in dv/ and a shortened power-up pause.
*/
module edr_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int INIT_N = 20;
  logic clk_sys, rst_b, req_valid, req_ready, rd_valid, self_req, self_act, init_done;
  logic ras_n, lower_column_strobe_n, upper_column_strobe_n, we_n, oe_n, dq_oe;
  logic [9:0]  mem_addr;
  logic [15:0] rd_data, dq_i, dq_o, rd;
  edr_pkg::edr_req_t req;
  int refreshes, faults, miscompares, checks, n, r0;

  edr_ctrl #(.INIT_CYC(INIT_N)) dut_u (.CLK_SYS(clk_sys), .RST_B(rst_b),
    .REQ_VALID(req_valid), .REQ(req), .REQ_READY(req_ready), .RD_VALID(rd_valid),
    .RD_DATA(rd_data), .SELF_REFRESH_REQ(self_req), .SELF_REFRESH_ACT(self_act),
    .INIT_DONE(init_done), .ROW_STROBE_N(ras_n),
    .LOWER_COLUMN_STROBE_N(lower_column_strobe_n),
    .UPPER_COLUMN_STROBE_N(upper_column_strobe_n), .WRITE_STROBE_N(we_n), .OUTPUT_GATE_N(oe_n),
    .MEM_ADDR(mem_addr), .DATA_LINES_I(dq_i), .DATA_LINES_O(dq_o), .DATA_LINES_OE(dq_oe));

  edr_mem_model mem_u (.clk(clk_sys), .ras_n(ras_n),
    .lower_column_strobe_n(lower_column_strobe_n),
    .upper_column_strobe_n(upper_column_strobe_n),
    .we_n(we_n), .oe_n(oe_n), .addr(mem_addr), .din(dq_o), .din_oe(dq_oe), .dout(dq_i),
    .refreshes(refreshes), .faults(faults));

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic tick(input int c);
    repeat (c) @(posedge clk_sys);
    #1;
  endtask

  function automatic logic pick(input int sel);
    case (sel)
      0:       return req_ready;
      1:       return rd_valid;
      2:       return init_done;
      default: return self_act;
    endcase
  endfunction

  // Bounded wait; returns the cycles spent in n
  task automatic wait_for(input string what, input int sel, input logic lvl, input int lim);
    n = 0;
    while (pick(sel) !== lvl) begin
      if (n == lim) begin
        check(what, 16'(pick(sel)), 16'(lvl));
        stop_test();
      end
      tick(1);
      n++;
    end
  endtask

  task automatic access(input logic wr, input logic [1:0] be, input logic [19:0] a,
                        input logic [15:0] wd);
    wait_for("ready", 0, 1'b1, 3000);
    req_valid = 1'b1;
    req = '{write: wr, be: be, addr: a, wdata: wd};
    tick(1);
    req_valid = 1'b0;
    check("ready after take", 16'(req_ready), 16'h0000);
    if (!wr) begin
      tick(2);
      check("read pulse", 16'(rd_valid), 16'h0001);
      rd = rd_data;
      tick(1);
      check("read pulse end", 16'(rd_valid), 16'h0000);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_init;
    check("strobes in reset", 16'({ras_n, lower_column_strobe_n, upper_column_strobe_n,
      dq_oe}), 16'h000E);
    rst_b = 1'b1;
    wait_for("init done", 2, 1'b1, 500);
    check("pause long enough", 16'(n >= INIT_N), 16'h0001);
    check("wake refreshes", 16'(refreshes >= 8), 16'h0001);
  endtask

  task automatic t_word;
    access(1'b1, 2'h3, 20'hABCDE, 16'h1234);
    access(1'b1, 2'h3, 20'h00123, 16'hA5C3);
    access(1'b0, 2'h3, 20'hABCDE, 16'h0000);
    check("word one", rd, 16'h1234);
    access(1'b0, 2'h3, 20'h00123, 16'h0000);
    check("word two", rd, 16'hA5C3);
  endtask

  task automatic t_lanes;
    access(1'b1, 2'h3, 20'h3FF00, 16'hFFFF);
    access(1'b1, 2'h1, 20'h3FF00, 16'h0011);
    access(1'b1, 2'h2, 20'h3FF00, 16'h2200);
    access(1'b0, 2'h3, 20'h3FF00, 16'h0000);
    check("merged lanes", rd, 16'h2211);
    access(1'b0, 2'h1, 20'h3FF00, 16'h0000);
    check("low lane only", {8'h00, rd[7:0]}, 16'h0011);
    access(1'b0, 2'h2, 20'h3FF00, 16'h0000);
    check("high lane only", {rd[15:8], 8'h00}, 16'h2200);
  endtask

  task automatic t_refresh;
    r0 = refreshes;
    tick(800);
    check("periodic refresh", 16'(refreshes - r0 >= 2), 16'h0001);
  endtask

  task automatic t_self;
    self_req = 1'b1;
    wait_for("self entry", 3, 1'b1, 3000);
    tick(50);
    self_req = 1'b0;
    wait_for("self exit", 3, 1'b0, 3000);
    check("self hold", 16'(n + 50 >= 2500), 16'h0001);
    access(1'b0, 2'h3, 20'hABCDE, 16'h0000);
    check("data after self", rd, 16'h1234);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_b = 1'b0;
    req_valid = 1'b0;
    req = '0;
    self_req = 1'b0;
    miscompares = 0;
    checks = 0;
    tick(3);
    t_init();
    t_word();
    t_lanes();
    t_refresh();
    t_self();
    check("model faults", 16'(faults), 16'h0000);
    stop_test();
  end
endmodule
